// ==== rtl/dma_bus_port.v ====
// Purpose: Runs one byte transaction on the system bus: a read of the source, then a write of the destination.
// Assumes: The slave holds mem_ack high for one cycle per access; mem_err is valid with mem_ack.
// Notes: A read error ends the transaction without a write.
`timescale 1ns/10ps
`include "dma_channel_map.vh"
module dma_bus_port (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // Engine side.
  input wire go,
  input wire [31:0] src_byte_addr,
  input wire [31:0] dst_byte_addr,
  output wire busy,
  output reg done,
  output reg err,
  output reg [7:0] data_byte,
  // System bus master.
  output reg mem_req,
  output reg mem_we,
  output reg [31:0] mem_addr,
  output reg [3:0] mem_be,
  output reg [31:0] mem_wdata,
  input wire mem_ack,
  input wire mem_err,
  input wire [31:0] mem_rdata
);
  localparam ST_IDLE = 2'd0;
  localparam ST_READ = 2'd1;
  localparam ST_WRITE = 2'd2;

  reg [1:0] state;
  reg [1:0] read_lane;
  wire [31:0] shifted_rdata;

  // The byte lane of the source address selects the byte read back.
  assign shifted_rdata = mem_rdata >> {read_lane, 3'b000};
  assign busy = (state != ST_IDLE);

  // Read phase then write phase, each held until the slave acknowledges.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      read_lane <= 2'b00;
      done <= 1'b0;
      err <= 1'b0;
      data_byte <= `RST_BYTE;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= `RST_WORD;
      mem_be <= 4'h0;
      mem_wdata <= `RST_WORD;
    end
    else
    begin
      done <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          if (go)
          begin
            state <= ST_READ;
            read_lane <= src_byte_addr[1:0];
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= {src_byte_addr[31:2], 2'b00};
            mem_be <= 4'h1 << src_byte_addr[1:0];
            err <= 1'b0;
          end
        end
        ST_READ:
        begin
          if (mem_ack)
          begin
            if (mem_err)
            begin
              state <= ST_IDLE;
              mem_req <= 1'b0;
              done <= 1'b1;
              err <= 1'b1;
            end
            else
            begin
              state <= ST_WRITE;
              data_byte <= shifted_rdata[7:0];
              mem_we <= 1'b1;
              mem_addr <= {dst_byte_addr[31:2], 2'b00};
              mem_be <= 4'h1 << dst_byte_addr[1:0];
              mem_wdata <= {4{shifted_rdata[7:0]}};
            end
          end
        end
        ST_WRITE:
        begin
          if (mem_ack)
          begin
            state <= ST_IDLE;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            done <= 1'b1;
            err <= mem_err;
          end
        end
        default:
        begin
          state <= ST_IDLE;
          mem_req <= 1'b0;
        end
      endcase
    end
  end
endmodule

// ==== rtl/dma_channel_engine.v ====
// Purpose: One DMA channel: registers over AXI4-Lite, start and abort events, pointer tracking, pattern match.
// Assumes: Interrupt events and the system bus run on core_clk; one byte moves per transaction.
// Notes: Start events arriving while a cell is running are ignored; abort events are not.
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`include "dma_channel_map.vh"
module dma_channel_engine (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // AXI4-Lite register slave.
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Device interrupt events.
  input wire irq_event_valid,
  input wire [7:0] irq_event_number,
  // System bus master.
  output wire mem_req,
  output wire mem_we,
  output wire [31:0] mem_addr,
  output wire [3:0] mem_be,
  output wire [31:0] mem_wdata,
  input wire mem_ack,
  input wire mem_err,
  input wire [31:0] mem_rdata,
  // Channel interrupt request.
  output reg channel_irq
);
  // Register state.
  reg controller_on;
  reg suspend;
  reg channel_enable;
  reg auto_reenable;
  reg [7:0] start_event_number;
  reg [7:0] abort_event_number;
  reg match_enable;
  reg start_event_enable;
  reg abort_event_enable;
  reg [7:0] flags;
  reg [7:0] flag_enables;
  reg [31:0] source_start_address;
  reg [31:0] dest_start_address;
  reg [7:0] source_size;
  reg [7:0] dest_size;
  reg [7:0] cell_size;
  reg [7:0] pattern_register;
  reg [7:0] source_pointer;
  reg [7:0] dest_pointer;
  reg [7:0] cell_pointer;
  reg [8:0] block_count;
  reg cell_active;
  reg abort_pending;
  // AXI write holding registers.
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // Size field to byte count, zero standing for 256.
  function [8:0] size_of;
    input [7:0] field;
    begin
      size_of = (field == 8'h00) ? `SIZE_ZERO_MEANS : {1'b0, field};
    end
  endfunction

  // Byte-strobe merge of write data into an old register value.
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    reg [31:0] mask;
    begin
      mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  // Transaction port wires.
  wire port_busy;
  wire txn_done;
  wire txn_err;
  wire [7:0] txn_byte;
  wire [31:0] src_byte_addr;
  wire [31:0] dst_byte_addr;
  wire go;

  // AXI handshakes: address and data are taken in either order.
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire rd_fire = s_axi_arvalid && !s_axi_rvalid;
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  // Decoded register writes.
  wire hit_ctrl = wr_fire && (aw_addr == `OFS_CONTROLLER_CTRL);
  wire hit_chan = wr_fire && (aw_addr == `OFS_CHANNEL_CTRL);
  wire hit_econ = wr_fire && (aw_addr == `OFS_EVENT_CTRL);
  wire hit_flag = wr_fire && (aw_addr == `OFS_CHANNEL_FLAG);
  wire hit_ssa = wr_fire && (aw_addr == `OFS_SOURCE_START);
  wire hit_dsa = wr_fire && (aw_addr == `OFS_DEST_START);
  wire [31:0] ctrl_new = merge({16'h0000, controller_on, 2'b00, suspend, 12'h000}, w_data, w_strb);
  wire [31:0] chan_new = merge({24'h00_0000, channel_enable, 2'b00, auto_reenable, 4'h0}, w_data, w_strb);
  wire [31:0] econ_new = merge({8'h00, abort_event_number, start_event_number, 2'b00, match_enable,
                                start_event_enable, abort_event_enable, 3'b000}, w_data, w_strb);
  wire force_wr = hit_econ && w_strb[0] && w_data[`BIT_FORCE_START];
  wire abort_wr = hit_econ && w_strb[0] && w_data[`BIT_ABORT_REQUEST];
  wire [7:0] flag_clr = (hit_flag && w_strb[0]) ? w_data[7:0] : 8'h00;

  // Events, sizes and the running condition.
  wire run_ok = controller_on && channel_enable;
  wire start_ev = run_ok && !cell_active && !abort_pending &&
                  (force_wr || (start_event_enable && irq_event_valid &&
                  (irq_event_number == start_event_number)));
  wire abort_ev = abort_wr || (abort_event_enable && irq_event_valid &&
                  (irq_event_number == abort_event_number));
  wire [8:0] src_total = size_of(source_size);
  wire [8:0] dst_total = size_of(dest_size);
  wire [8:0] block_size = (src_total > dst_total) ? src_total : dst_total;
  wire [8:0] src_next = {1'b0, source_pointer} + 9'h001;
  wire [8:0] dst_next = {1'b0, dest_pointer} + 9'h001;
  wire [8:0] cell_next = {1'b0, cell_pointer} + 9'h001;
  wire [8:0] block_next = block_count + 9'h001;
  wire src_wrap = (src_next == src_total);
  wire dst_wrap = (dst_next == dst_total);
  wire block_end = (block_next == block_size);
  wire cell_end = (cell_next == size_of(cell_size)) || block_end;
  wire txn_ok = txn_done && !txn_err;
  wire pattern_hit = match_enable && (txn_byte == pattern_register);
  wire complete = txn_ok && (block_end || pattern_hit);
  wire apply_abort = abort_pending && !port_busy && !txn_done;
  wire keep_pointers = suspend || (!channel_enable && cell_active);

  assign go = cell_active && run_ok && !suspend && !port_busy && !abort_pending && !txn_done;
  assign src_byte_addr = source_start_address + {24'h00_0000, source_pointer};
  assign dst_byte_addr = dest_start_address + {24'h00_0000, dest_pointer};

  // Flag set terms collected from the datapath.
  reg [7:0] flag_set;
  always @*
  begin
    flag_set = 8'h00;
    if (txn_ok)
    begin
      flag_set[`FLAG_SOURCE_HALF] = (src_next == (src_total >> 1));
      flag_set[`FLAG_DEST_HALF] = (dst_next == (dst_total >> 1));
      flag_set[`FLAG_SOURCE_DONE] = src_wrap;
      flag_set[`FLAG_DEST_DONE] = dst_wrap;
      flag_set[`FLAG_CELL_DONE] = cell_end || complete;
      flag_set[`FLAG_BLOCK_COMPLETE] = complete;
    end
    if (txn_done && txn_err)
      flag_set[`FLAG_ADDRESS_ERROR] = 1'b1;
    if (apply_abort)
      flag_set[`FLAG_ABORT] = 1'b1;
  end

  // AXI write channel capture and response.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= `RST_BYTE;
      w_data <= `RST_WORD;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > `OFS_PATTERN) ? `RESP_SLVERR : `RESP_OKAY;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // AXI read channel: data registered one cycle after the address is taken.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `RST_WORD;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `OFS_CONTROLLER_CTRL: s_axi_rdata <= {16'h0000, controller_on, 2'b00, suspend, 12'h000};
        `OFS_CHANNEL_CTRL: s_axi_rdata <= {24'h00_0000, channel_enable, 2'b00, auto_reenable, 4'h0};
        `OFS_EVENT_CTRL: s_axi_rdata <= {8'h00, abort_event_number, start_event_number, 2'b00,
                                         match_enable, start_event_enable, abort_event_enable, 3'b000};
        `OFS_CHANNEL_FLAG: s_axi_rdata <= {8'h00, flag_enables, 8'h00, flags};
        `OFS_SOURCE_START: s_axi_rdata <= source_start_address;
        `OFS_DEST_START: s_axi_rdata <= dest_start_address;
        `OFS_SOURCE_SIZE: s_axi_rdata <= {24'h00_0000, source_size};
        `OFS_DEST_SIZE: s_axi_rdata <= {24'h00_0000, dest_size};
        `OFS_SOURCE_POINTER: s_axi_rdata <= {24'h00_0000, source_pointer};
        `OFS_DEST_POINTER: s_axi_rdata <= {24'h00_0000, dest_pointer};
        `OFS_CELL_SIZE: s_axi_rdata <= {24'h00_0000, cell_size};
        `OFS_CELL_POINTER: s_axi_rdata <= {24'h00_0000, cell_pointer};
        `OFS_PATTERN: s_axi_rdata <= {24'h00_0000, pattern_register};
        default:
        begin
          s_axi_rdata <= `RST_WORD;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Configuration registers; pointer registers take no software writes.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      controller_on <= 1'b0;
      suspend <= 1'b0;
      auto_reenable <= 1'b0;
      start_event_number <= `RST_BYTE;
      abort_event_number <= `RST_BYTE;
      match_enable <= 1'b0;
      start_event_enable <= 1'b0;
      abort_event_enable <= 1'b0;
      flag_enables <= `RST_BYTE;
      source_start_address <= `RST_WORD;
      dest_start_address <= `RST_WORD;
      source_size <= `RST_BYTE;
      dest_size <= `RST_BYTE;
      cell_size <= `RST_BYTE;
      pattern_register <= `RST_BYTE;
    end
    else
    begin
      if (hit_ctrl)
      begin
        controller_on <= ctrl_new[`BIT_CONTROLLER_ON];
        suspend <= ctrl_new[`BIT_SUSPEND];
      end
      if (hit_chan)
        auto_reenable <= chan_new[`BIT_AUTO_REENABLE];
      if (hit_econ)
      begin
        abort_event_number <= econ_new[`ABORT_NUM_HI:`ABORT_NUM_LO];
        start_event_number <= econ_new[`START_NUM_HI:`START_NUM_LO];
        match_enable <= econ_new[`BIT_MATCH_ENABLE];
        start_event_enable <= econ_new[`BIT_START_ENABLE];
        abort_event_enable <= econ_new[`BIT_ABORT_ENABLE];
      end
      if (hit_flag && w_strb[2])
        flag_enables <= w_data[`FLAG_ENABLE_LO+7:`FLAG_ENABLE_LO];
      if (hit_ssa)
        source_start_address <= merge(source_start_address, w_data, w_strb);
      if (hit_dsa)
        dest_start_address <= merge(dest_start_address, w_data, w_strb);
      if (wr_fire && (aw_addr == `OFS_SOURCE_SIZE) && w_strb[0])
        source_size <= w_data[7:0];
      if (wr_fire && (aw_addr == `OFS_DEST_SIZE) && w_strb[0])
        dest_size <= w_data[7:0];
      if (wr_fire && (aw_addr == `OFS_CELL_SIZE) && w_strb[0])
        cell_size <= w_data[7:0];
      if (wr_fire && (aw_addr == `OFS_PATTERN) && w_strb[0])
        pattern_register <= w_data[7:0];
    end
  end

  // Sticky flags, set winning over a software clear, and the gated interrupt.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      flags <= `RST_BYTE;
      channel_irq <= 1'b0;
    end
    else
    begin
      flags <= (flags & ~flag_clr) | flag_set;
      channel_irq <= |(((flags & ~flag_clr) | flag_set) & flag_enables);
    end
  end

  // Channel sequencing: cells, pointers, completion and aborts; later assignments take priority.
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      channel_enable <= 1'b0;
      source_pointer <= `RST_BYTE;
      dest_pointer <= `RST_BYTE;
      cell_pointer <= `RST_BYTE;
      block_count <= `RST_COUNT;
      cell_active <= 1'b0;
      abort_pending <= 1'b0;
    end
    else
    begin
      if (hit_chan)
        channel_enable <= chan_new[`BIT_CHANNEL_ENABLE];
      if (start_ev)
      begin
        cell_active <= 1'b1;
        cell_pointer <= `RST_BYTE;
      end
      if (txn_ok)
      begin
        source_pointer <= src_wrap ? `RST_BYTE : src_next[7:0];
        dest_pointer <= dst_wrap ? `RST_BYTE : dst_next[7:0];
        cell_pointer <= cell_next[7:0];
        block_count <= block_next;
        if (cell_end)
          cell_active <= 1'b0;
      end
      if (complete)
      begin
        source_pointer <= `RST_BYTE;
        dest_pointer <= `RST_BYTE;
        cell_pointer <= `RST_BYTE;
        block_count <= `RST_COUNT;
        cell_active <= 1'b0;
        if (!auto_reenable)
          channel_enable <= 1'b0;
      end
      if (abort_ev || (txn_done && txn_err))
        abort_pending <= 1'b1;
      if (apply_abort)
      begin
        abort_pending <= 1'b0;
        cell_active <= 1'b0;
        if (!keep_pointers)
        begin
          source_pointer <= `RST_BYTE;
          dest_pointer <= `RST_BYTE;
          cell_pointer <= `RST_BYTE;
          block_count <= `RST_COUNT;
        end
      end
      if (hit_ssa)
        source_pointer <= `RST_BYTE;
      if (hit_dsa)
        dest_pointer <= `RST_BYTE;
      if (!controller_on)
      begin
        source_pointer <= `RST_BYTE;
        dest_pointer <= `RST_BYTE;
        cell_pointer <= `RST_BYTE;
        block_count <= `RST_COUNT;
        cell_active <= 1'b0;
      end
    end
  end

  // Bus transaction port.
  dma_bus_port u_bus_port (
    .core_clk(core_clk),
    .rst(rst),
    .go(go),
    .src_byte_addr(src_byte_addr),
    .dst_byte_addr(dst_byte_addr),
    .busy(port_busy),
    .done(txn_done),
    .err(txn_err),
    .data_byte(txn_byte),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_be(mem_be),
    .mem_wdata(mem_wdata),
    .mem_ack(mem_ack),
    .mem_err(mem_err),
    .mem_rdata(mem_rdata)
  );
endmodule

// ==== rtl/dma_channel_map.vh ====
// Purpose: Register offsets, field positions and reset values of the DMA channel transfer engine.
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register.
// Notes: Included by the engine and its bus port; definitions only.
// Overview of operation
// - Move data only with controller and channel enabled.
// - Force-start bit starts a cell transfer.
// - Matching start interrupt starts a cell transfer.
// - Each start moves cell-size bytes, then waits.
// - Read-only source/destination pointers advance per transaction.
// - Half and done flags at size/2 and size.
// - Pointers clear on reset, off, completion, abort.
// - Abort while disabled or suspended keeps pointers; the code keeps them when disabled only if a cell is active.
// - Start address writes clear matching pointer.
// - Completion clears enable unless auto re-enable.
// - Abort on request write, matching abort event, bus error.
// - Abort sets flag after current transaction finishes.
// - Transaction is one read then one write.
// - Block is larger size; completes after that.
// - Pointers wrap to zero at their sizes.
// - Cell never moves more than block size.
// - Written bytes compared with pattern when enabled.
// - Match acts as block completion, sets flag.
// - Size value zero means 256 bytes.
// - Cell pointer counts bytes since last start.
`ifndef DMA_CHANNEL_MAP_VH
`define DMA_CHANNEL_MAP_VH

// Register byte offsets.
`define OFS_CONTROLLER_CTRL 8'h00
`define OFS_CHANNEL_CTRL 8'h04
`define OFS_EVENT_CTRL 8'h08
`define OFS_CHANNEL_FLAG 8'h0C
`define OFS_SOURCE_START 8'h10
`define OFS_DEST_START 8'h14
`define OFS_SOURCE_SIZE 8'h18
`define OFS_DEST_SIZE 8'h1C
`define OFS_SOURCE_POINTER 8'h20
`define OFS_DEST_POINTER 8'h24
`define OFS_CELL_SIZE 8'h28
`define OFS_CELL_POINTER 8'h2C
`define OFS_PATTERN 8'h30

// Controller control fields.
`define BIT_CONTROLLER_ON 15
`define BIT_SUSPEND 12
// Channel control fields.
`define BIT_CHANNEL_ENABLE 7
`define BIT_AUTO_REENABLE 4
// Event control fields.
`define ABORT_NUM_HI 23
`define ABORT_NUM_LO 16
`define START_NUM_HI 15
`define START_NUM_LO 8
`define BIT_FORCE_START 7
`define BIT_ABORT_REQUEST 6
`define BIT_MATCH_ENABLE 5
`define BIT_START_ENABLE 4
`define BIT_ABORT_ENABLE 3
// Channel flag positions; enables sit 16 bits higher.
`define FLAG_ADDRESS_ERROR 0
`define FLAG_ABORT 1
`define FLAG_CELL_DONE 2
`define FLAG_BLOCK_COMPLETE 3
`define FLAG_DEST_HALF 4
`define FLAG_DEST_DONE 5
`define FLAG_SOURCE_HALF 6
`define FLAG_SOURCE_DONE 7
`define FLAG_ENABLE_LO 16

// Reset values.
`define RST_BYTE 8'h00
`define RST_WORD 32'h0000_0000
`define RST_COUNT 9'h000
`define SIZE_ZERO_MEANS 9'h100

// AXI responses.
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== tb/dma_channel_engine_monitor.sv ====
// Purpose: Port checks of the DMA channel engine.
// Assumes: One clock; rst synchronous, active high.
// Notes: Bound to every engine instance.
`timescale 1ns/10ps
module dma_channel_engine_monitor (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // Register bus.
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // System bus.
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [3:0] mem_be,
  input wire mem_ack,
  input wire mem_err
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Register bus answer timing.
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && !s_axi_bvalid |-> ##2 s_axi_bvalid) else $error("write answer late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
  read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  // Bus accesses hold and pair read with write.
  req_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("bus access dropped");
  read_then_write_a: assert property (mem_req && !mem_we && mem_ack && !mem_err |=> mem_req && mem_we)
    else $error("read not followed by write");
  write_gap_a: assert property (mem_req && mem_we && mem_ack |=> !mem_req) else $error("no gap after write");
  error_stop_a: assert property (mem_req && mem_ack && mem_err |=> !mem_req) else $error("write after error");
  one_lane_a: assert property (mem_req |-> $onehot(mem_be) && mem_addr[1:0] == 2'b00)
    else $error("bad byte lane");
endmodule
bind dma_channel_engine dma_channel_engine_monitor u_dma_channel_engine_monitor (.core_clk, .rst,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_ack, .mem_err);

// ==== tb/dma_channel_engine_test.sv ====
// Purpose: Self-checking bench of the DMA channel engine.
// Assumes: The memory model returns address low bytes.
// Notes: Register rows, then transfers and aborts.
`timescale 1ns/10ps
module dma_channel_engine_test;
  reg core_clk = 1'b0;
  reg rst = 1'b1;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg irq_event_valid = 1'b0, slow = 1'b0;
  reg [7:0] s_axi_awaddr, s_axi_araddr, irq_event_number;
  reg [31:0] s_axi_wdata;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, mem_addr, mem_wdata, mem_rdata;
  wire mem_req, mem_we, mem_ack, mem_err, channel_irq;
  wire [3:0] mem_be;
  wire [7:0] last_byte, writes;
  integer failures = 0;
  integer compares = 0;
  integer cycles = 0;
  integer i;
  // Rows: address, data written, data read.
  localparam [71:0] rows [0:5] = '{{8'h30, 32'h1234_56A5, 32'h0000_00A5},
    {8'h18, 32'h0000_0104, 32'h0000_0004}, {8'h20, 32'h0000_00FF, 32'h0000_0000},
    {8'h08, 32'h00AB_CDB8, 32'h00AB_CD38}, {8'h14, 32'hDEAD_BEEF, 32'hDEAD_BEEF},
    {8'h34, 32'hFFFF_FFFF, 32'h0000_0000}};
  dma_channel_engine u_dma_channel_engine (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .irq_event_valid, .irq_event_number, .mem_req, .mem_we, .mem_addr, .mem_be, .mem_wdata, .mem_ack,
    .mem_err, .mem_rdata, .channel_irq);
  dma_mem_model u_dma_mem_model (.core_clk, .rst, .mem_req, .mem_we, .mem_addr, .mem_wdata, .mem_ack,
    .mem_err, .mem_rdata, .slow, .last_byte, .writes);
  // Clock and hang guard.
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 40000)
    begin
      failures = failures + 1;
      test_done;
    end
  end
  task test_done;
    begin
      if (failures == 0 && compares > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp)
      begin
        failures = failures + 1;
        $display("unexpected %0s: expected %h, seen %h", name, exp, seen);
      end
    end
  endtask
  // Register write.
  task wr(input [7:0] a, input [31:0] d);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(posedge core_clk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      chk("bresp", s_axi_bresp, {a > 8'h30, 1'b0});
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge core_clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge core_clk); while (!s_axi_rvalid);
      chk($sformatf("reg %h", a), s_axi_rdata, e);
      chk("rresp", s_axi_rresp, {a > 8'h30, 1'b0});
    end
  endtask
  // Waits for the write count, settles, checks it.
  task tw(input [7:0] n);
    begin
      for (i = 0; i < 300 && writes !== n; i = i + 1)
        @(posedge core_clk);
      repeat (12) @(posedge core_clk);
      chk("writes", writes, n);
    end
  endtask
  task pulse(input [7:0] n);
    begin
      irq_event_number <= n;
      irq_event_valid <= 1'b1;
      @(posedge core_clk);
      irq_event_valid <= 1'b0;
    end
  endtask
  // Main sequence.
  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rc(8'h18, 32'h0000_0000);
    for (i = 0; i < 6; i = i + 1)
    begin
      wr(rows[i][71:64], rows[i][63:32]);
      rc(rows[i][71:64], rows[i][31:0]);
    end
    // Whole block, cell larger than block.
    wr(8'h00, 32'h0000_8000);
    wr(8'h10, 32'h0000_0100);
    wr(8'h14, 32'h0000_0200);
    wr(8'h1C, 32'h0000_0002);
    wr(8'h28, 32'h0000_0000);
    wr(8'h0C, 32'h00FF_00FF);
    wr(8'h04, 32'h0000_0080);
    wr(8'h08, 32'h0000_0080);
    tw(8'd4);
    chk("byte", last_byte, 32'h0000_0003);
    chk("irq", channel_irq, 32'h0000_0001);
    rc(8'h0C, 32'h00FF_00FC);
    rc(8'h04, 32'h0000_0000);
    rc(8'h20, 32'h0000_0000);
    wr(8'h08, 32'h0000_0080);
    tw(8'd4);
    // One-byte cell, source restart, abort.
    wr(8'h0C, 32'h00FF_00FF);
    wr(8'h28, 32'h0000_0001);
    wr(8'h04, 32'h0000_0080);
    wr(8'h08, 32'h0000_0080);
    tw(8'd5);
    rc(8'h2C, 32'h0000_0001);
    wr(8'h10, 32'h0000_0100);
    rc(8'h20, 32'h0000_0000);
    rc(8'h24, 32'h0000_0001);
    wr(8'h08, 32'h0000_0040);
    tw(8'd5);
    rc(8'h24, 32'h0000_0000);
    rc(8'h0C, 32'h00FF_0016);
    // Start events, then an abort event.
    wr(8'h0C, 32'h00FF_00FF);
    wr(8'h08, 32'h0000_2A10);
    pulse(8'h2B);
    tw(8'd5);
    pulse(8'h2A);
    tw(8'd6);
    wr(8'h08, 32'h0033_0008);
    pulse(8'h33);
    tw(8'd6);
    rc(8'h0C, 32'h00FF_0016);
    // Pattern match on the third byte, slow memory.
    slow <= 1'b1;
    wr(8'h0C, 32'h00FF_00FF);
    wr(8'h18, 32'h0000_0000);
    wr(8'h1C, 32'h0000_0000);
    wr(8'h28, 32'h0000_0000);
    wr(8'h30, 32'h0000_0042);
    wr(8'h10, 32'h0000_0140);
    wr(8'h08, 32'h0000_00A0);
    tw(8'd9);
    chk("byte", last_byte, 32'h0000_0042);
    rc(8'h04, 32'h0000_0000);
    rc(8'h0C, 32'h00FF_000C);
    // Source read error ends the transfer.
    wr(8'h0C, 32'h00FF_00FF);
    wr(8'h04, 32'h0000_0080);
    wr(8'h10, 32'hF000_0000);
    wr(8'h08, 32'h0000_0080);
    tw(8'd9);
    rc(8'h0C, 32'h00FF_0003);
    wr(8'h00, 32'h0000_0000);
    test_done;
  end
endmodule

// ==== tb/dma_mem_model.sv ====
// Purpose: Memory slave on the engine's system bus.
// Assumes: Each byte reads back as the low byte of its address.
// Notes: Addresses with top nibble F answer with an error.
`timescale 1ns/10ps
module dma_mem_model (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // System bus slave.
  input wire mem_req,
  input wire mem_we,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  output reg mem_ack,
  output reg mem_err,
  output reg [31:0] mem_rdata,
  // Bench view.
  input wire slow,
  output reg [7:0] last_byte,
  output reg [7:0] writes
);
  reg [2:0] wait_cnt;
  // One answer per access; read data toggles when idle.
  always @(posedge core_clk)
  begin
    mem_ack <= 1'b0;
    mem_err <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (rst)
    begin
      wait_cnt <= 3'd0;
      writes <= 8'h00;
      mem_rdata <= 32'h0000_0000;
    end
    else if (mem_req && !mem_ack)
    begin
      wait_cnt <= wait_cnt + 3'd1;
      if (wait_cnt == (slow ? 3'd5 : 3'd0))
      begin
        wait_cnt <= 3'd0;
        mem_ack <= 1'b1;
        mem_err <= mem_addr[31:28] == 4'hF;
        mem_rdata <= {4{mem_addr[7:0]}} + 32'h0302_0100;
        if (mem_we)
        begin
          writes <= writes + 8'h01;
          last_byte <= mem_wdata[7:0];
        end
      end
    end
  end
endmodule
